/* src/irq_ctrl_cfg.svh */
// address map, field positions and timing counts for the interrupt and soft-reset controller
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

// ----------------------------------------------------------------
// address map (24-bit local/backplane-window addresses)
// ----------------------------------------------------------------
`define ADDR_W 24
`define RESET_REGION_NIB 4'hf
`define CTRL_REGION_NIB 4'hc
`define ADDR_STATUS 24'hc00000
`define ADDR_CLR_TIMER 24'hc00002
`define ADDR_CLR_HOST 24'hc00004
`define ADDR_SET_HOST 24'hc00006
`define ADDR_CLR_PROC 24'hca0008
`define ADDR_SET_PROC 24'hca000a
`define ADDR_CLR_FWD 24'hca000c
`define ADDR_SET_FWD 24'hca000e
`define ADDR_TMR_HI 24'hca000b
`define ADDR_TMR_LO 24'hca0009
`define ADDR_TMR_CNT_HI 24'hc00006
`define ADDR_TMR_CNT_LO 24'hc00004

// ----------------------------------------------------------------
// status byte field positions
// ----------------------------------------------------------------
`define BIT_FWD_MODE 7
`define BIT_TIMER 6
`define BIT_PROC 5
`define BIT_HOST 4

// ----------------------------------------------------------------
// levels and timing
// ----------------------------------------------------------------
`define LVL_TIMER 3'd1
`define LVL_HOST 3'd2
`define LVL_IO 3'd3
`define CLK_NS 100
`define TICK_NS 25600
`define TICK_CYC (`TICK_NS / `CLK_NS)
`define TIMER_RESET 16'h0000

`endif

/* src/irq_ctrl_pkg.sv */
// shared types for the interrupt and soft-reset controller
package irq_ctrl_pkg;
	// one bus access as seen by the controller
	typedef struct packed {
		logic valid; // one-cycle strobe per access
		logic write; // 1 = write, 0 = read
		logic upper; // upper byte lane selected
		logic lower; // lower byte lane selected
		logic [23:0] addr; // byte address
		logic [7:0] wdata; // write data, lower lane
	} bus_req_t;

	typedef enum logic [1:0] {
		BOOT_ROM = 2'b00,
		BOOT_RAM = 2'b01
	} boot_src_t;

	typedef enum logic [0:0] {
		RUN = 1'b0,
		HELD = 1'b1
	} sreset_state_t;
endpackage

/* src/tick_timer.sv */
// 16-bit reloading down-counter that flags each pass through zero
`include "irq_ctrl_cfg.svh"
module tick_timer #(
	parameter int TICK_CYCLES = `TICK_CYC,
	parameter int WIDTH = 16
) (
	input wire logic clock, // controller clock
	input wire logic srst, // synchronous reset
	input wire logic [WIDTH-1:0] reload, // holding register value
	output logic [WIDTH-1:0] count, // current count
	output logic zero_pulse // one cycle when zero is reached
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	logic [TW-1:0] tick_q;
	logic tick;
	logic [WIDTH-1:0] count_q;

	assign tick = (tick_q == TW'(TICK_CYCLES - 1));
	assign count = count_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			tick_q <= '0;
		end else if (tick) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_q + 1'b1;
		end
	end

	// reload happens on the tick after zero, so zero lasts one full tick
	always_ff @(posedge clock) begin
		if (srst) begin
			count_q <= `TIMER_RESET;
			zero_pulse <= 1'b0;
		end else begin
			zero_pulse <= 1'b0;
			if (tick) begin
				if (count_q == '0) begin
					count_q <= reload;
				end else begin
					count_q <= count_q - 1'b1;
					zero_pulse <= (count_q == WIDTH'(1));
				end
			end
		end
	end
endmodule

/* src/level_encoder.sv */
// picks the highest pending local interrupt and encodes it active low
`include "irq_ctrl_cfg.svh"
module level_encoder (
	input wire logic timer_irq, // level 1 source
	input wire logic host_irq, // level 2 source
	input wire logic io_irq, // level 3 source
	output logic [2:0] level_n // encoded level, active low
);
	logic [2:0] lvl;

	always_comb begin
		lvl = 3'd0;
		if (io_irq) begin
			lvl = `LVL_IO;
		end else if (host_irq) begin
			lvl = `LVL_HOST;
		end else if (timer_irq) begin
			lvl = `LVL_TIMER;
		end
		level_n = ~lvl;
	end
endmodule

/* src/coproc_irq_soft_reset_ctrl.sv */
// interrupt ranking, soft-reset and boot-vector control for the coprocessor card
`include "irq_ctrl_cfg.svh"
// Functional notes
// - any backplane write into the top local region puts the processor in soft reset
// - any upper-byte access to the control region releases soft reset
// - backplane reset going low releases soft reset
// - first four fetches go to ROM after power-on, RAM after soft reset
// - power-on reset clears all registers; soft reset leaves them unchanged
// - timer is level 1, host level 2, I/O interface level 3
// - timer interrupt set at zero, held until byte read of clear address
// - status upper nibble reports mode, timer, host-to-proc, proc-to-host, active low
// - status lower nibble returns current slot number, active high
// - host read of set address raises level 2; local read of clear drops it
// - I/O interface input gives level 3 with no status bit
// - local read of set address asserts backplane request; host read clears it
// - two upper-byte reads enable and disable request forwarding mode
// - in forwarding mode an external request gives level 2, no status bit
// - with host request and forwarding both on, either input sets host-to-proc bit
// - status bits read 0 when set or true, 1 when cleared
// - timer is 16-bit down-counter on fixed tick, reloads after zero
module coproc_irq_soft_reset_ctrl #(
	parameter int TICK_CYCLES = `TICK_CYC, // timer tick in clocks, 25.6 us
	parameter int VEC_FETCHES = 4 // fetches redirected after reset
) (
	input wire logic clock, // controller clock, 10 MHz
	input wire logic srst, // backplane power-on reset, active high
	input wire irq_ctrl_pkg::bus_req_t host_req, // access from the backplane host
	input wire irq_ctrl_pkg::bus_req_t local_req, // access from the local processor
	input wire logic local_fetch, // one cycle per local processor fetch
	input wire logic [3:0] slot_id, // card slot number
	input wire logic io_side_irq_in_n, // I/O interface request, active low
	input wire logic nmrq_in_n, // backplane request line as sensed, active low
	input wire logic bp_reset_n, // backplane reset line level, active low
	output logic [7:0] rdata, // read data for the local bus, lower lane
	output logic [2:0] irq_priority_lines, // encoded level, active low
	output logic nmrq_out_n, // drive request onto backplane, active low
	output logic proc_reset_n, // soft reset to local processor, active low
	output logic boot_from_ram // redirect vector fetches to RAM at zero
);
	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	logic h_wr_top, any_up_ctrl;

	function automatic logic up_read(input irq_ctrl_pkg::bus_req_t r, input logic [23:0] a);
		up_read = r.valid && !r.write && r.upper && (r.addr == a);
	endfunction

	function automatic logic lo_write(input irq_ctrl_pkg::bus_req_t r, input logic [23:0] a);
		lo_write = r.valid && r.write && r.lower && (r.addr == a);
	endfunction

	function automatic logic in_ctrl(input irq_ctrl_pkg::bus_req_t r);
		in_ctrl = r.valid && r.upper && (r.addr[23:20] == `CTRL_REGION_NIB);
	endfunction

	// the valid strobe is one cycle, so every action fires once per access
	assign h_wr_top = host_req.valid && host_req.write
		&& (host_req.addr[23:20] == `RESET_REGION_NIB);
	assign any_up_ctrl = in_ctrl(host_req) || in_ctrl(local_req);

	// ----------------------------------------------------------------
	// soft reset and boot source
	// ----------------------------------------------------------------
	irq_ctrl_pkg::sreset_state_t sr_q;
	irq_ctrl_pkg::boot_src_t boot_q;
	logic [2:0] fetch_q;
	logic bp_reset_d1_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			bp_reset_d1_q <= 1'b1;
		end else begin
			bp_reset_d1_q <= bp_reset_n;
		end
	end

	// release wins over entry when both arrive together
	always_ff @(posedge clock) begin
		if (srst) begin
			sr_q <= irq_ctrl_pkg::RUN;
		end else if (bp_reset_d1_q && !bp_reset_n) begin
			sr_q <= irq_ctrl_pkg::RUN;
		end else if (any_up_ctrl) begin
			sr_q <= irq_ctrl_pkg::RUN;
		end else if (h_wr_top) begin
			sr_q <= irq_ctrl_pkg::HELD;
		end
	end

	// redirection to RAM lasts for the first fetches after a soft reset only; power-on leaves boot_q at ROM
	always_ff @(posedge clock) begin
		if (srst) begin
			boot_q <= irq_ctrl_pkg::BOOT_ROM;
			fetch_q <= '0;
		end else if (sr_q == irq_ctrl_pkg::HELD) begin
			boot_q <= irq_ctrl_pkg::BOOT_RAM;
			fetch_q <= '0;
		end else if (local_fetch && fetch_q != 3'(VEC_FETCHES)) begin
			fetch_q <= fetch_q + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			proc_reset_n <= 1'b0;
			boot_from_ram <= 1'b0;
		end else begin
			proc_reset_n <= (sr_q == irq_ctrl_pkg::RUN);
			boot_from_ram <= (boot_q == irq_ctrl_pkg::BOOT_RAM)
				&& (fetch_q != 3'(VEC_FETCHES));
		end
	end

	// ----------------------------------------------------------------
	// timer and holding register
	// ----------------------------------------------------------------
	logic [15:0] reload_q, count;
	logic zero_pulse;

	// soft reset does not touch any of these registers
	always_ff @(posedge clock) begin
		if (srst) begin
			reload_q <= `TIMER_RESET;
		end else begin
			if (lo_write(local_req, `ADDR_TMR_HI)) begin
				reload_q[15:8] <= local_req.wdata;
			end
			if (lo_write(local_req, `ADDR_TMR_LO)) begin
				reload_q[7:0] <= local_req.wdata;
			end
		end
	end

	tick_timer #(
		.TICK_CYCLES(TICK_CYCLES),
		.WIDTH(16)
	) u_timer (
		.clock(clock),
		.srst(srst),
		.reload(reload_q),
		.count(count),
		.zero_pulse(zero_pulse)
	);

	// ----------------------------------------------------------------
	// interrupt flags, set wins over clear
	// ----------------------------------------------------------------
	logic timer_q, proc_q, host_q, fwd_q;
	logic clr_timer;

	assign clr_timer = local_req.valid && !local_req.write
		&& (local_req.upper ^ local_req.lower)
		&& (local_req.addr == `ADDR_CLR_TIMER);

	always_ff @(posedge clock) begin
		if (srst) begin
			timer_q <= 1'b0;
		end else if (zero_pulse) begin
			timer_q <= 1'b1;
		end else if (clr_timer) begin
			timer_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			proc_q <= 1'b0;
		end else if (up_read(host_req, `ADDR_SET_PROC)) begin
			proc_q <= 1'b1;
		end else if (up_read(local_req, `ADDR_CLR_PROC)) begin
			proc_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			host_q <= 1'b0;
		end else if (up_read(local_req, `ADDR_SET_HOST)) begin
			host_q <= 1'b1;
		end else if (up_read(host_req, `ADDR_CLR_HOST)) begin
			host_q <= 1'b0;
		end
	end

	// either party may switch the mode; set wins over clear
	always_ff @(posedge clock) begin
		if (srst) begin
			fwd_q <= 1'b0;
		end else if (up_read(host_req, `ADDR_SET_FWD) || up_read(local_req, `ADDR_SET_FWD)) begin
			fwd_q <= 1'b1;
		end else if (up_read(host_req, `ADDR_CLR_FWD) || up_read(local_req, `ADDR_CLR_FWD)) begin
			fwd_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// level outputs
	// ----------------------------------------------------------------
	logic io_irq, fwd_irq, poll_hit;
	logic [2:0] level_d;

	assign io_irq = !io_side_irq_in_n;
	// own request must not loop back through the forwarding path
	assign fwd_irq = fwd_q && !nmrq_in_n && !host_q;
	assign poll_hit = host_q && fwd_q && (io_irq || !nmrq_in_n);

	level_encoder u_enc (
		.timer_irq(timer_q),
		.host_irq(proc_q || fwd_irq),
		.io_irq(io_irq),
		.level_n(level_d)
	);

	always_ff @(posedge clock) begin
		if (srst) begin
			irq_priority_lines <= 3'h7;
			nmrq_out_n <= 1'b1;
		end else begin
			irq_priority_lines <= level_d;
			nmrq_out_n <= !host_q;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [7:0] status_byte;

	always_comb begin
		status_byte = {4'hf, slot_id};
		status_byte[`BIT_FWD_MODE] = !fwd_q;
		status_byte[`BIT_TIMER] = !timer_q;
		status_byte[`BIT_PROC] = !(proc_q || poll_hit);
		status_byte[`BIT_HOST] = !host_q;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata <= 8'h00;
		end else if (local_req.valid && !local_req.write) begin
			unique case (local_req.addr)
				`ADDR_STATUS: rdata <= status_byte;
				`ADDR_TMR_CNT_HI: rdata <= count[15:8];
				`ADDR_TMR_CNT_LO: rdata <= count[7:0];
				default: rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_softreset_entry: assert property (@(posedge clock) disable iff (srst)
		h_wr_top && !any_up_ctrl && bp_reset_n |=> ##1 !proc_reset_n)
		else $error("soft reset not entered");
	chk_softreset_exit: assert property (@(posedge clock) disable iff (srst)
		any_up_ctrl |=> ##1 proc_reset_n)
		else $error("soft reset not released");
	chk_bpreset_exit: assert property (@(posedge clock) disable iff (srst)
		$fell(bp_reset_n) |=> ##1 proc_reset_n)
		else $error("backplane reset did not release");
	chk_boot_ram: assert property (@(posedge clock) disable iff (srst)
		sr_q == irq_ctrl_pkg::HELD |=> ##1 boot_from_ram)
		else $error("vector fetches not sent to RAM");
	chk_timer_hold: assert property (@(posedge clock) disable iff (srst)
		timer_q && !clr_timer |=> timer_q)
		else $error("timer flag dropped without clear");
	chk_timer_set: assert property (@(posedge clock) disable iff (srst)
		zero_pulse |=> timer_q && !status_byte[`BIT_TIMER])
		else $error("timer flag not set");
	chk_timer_clear: assert property (@(posedge clock) disable iff (srst)
		clr_timer && !zero_pulse |=> !timer_q)
		else $error("timer flag not cleared");
	chk_host_level: assert property (@(posedge clock) disable iff (srst)
		up_read(host_req, `ADDR_SET_PROC) ##1 io_side_irq_in_n
		|=> irq_priority_lines == ~`LVL_HOST)
		else $error("level 2 not raised");
	chk_proc_clear: assert property (@(posedge clock) disable iff (srst)
		up_read(local_req, `ADDR_CLR_PROC) && !up_read(host_req, `ADDR_SET_PROC) |=> !proc_q)
		else $error("host-to-processor flag not dropped");
	chk_io_level: assert property (@(posedge clock) disable iff (srst)
		!io_side_irq_in_n |=> irq_priority_lines == ~`LVL_IO)
		else $error("level 3 not shown");
	chk_nmrq_drive: assert property (@(posedge clock) disable iff (srst)
		up_read(local_req, `ADDR_SET_HOST) |=> ##1 !nmrq_out_n)
		else $error("backplane request not driven");
	chk_host_clear: assert property (@(posedge clock) disable iff (srst)
		up_read(host_req, `ADDR_CLR_HOST) && !up_read(local_req, `ADDR_SET_HOST)
		|=> ##1 nmrq_out_n)
		else $error("backplane request not released");
	chk_fwd_mode: assert property (@(posedge clock) disable iff (srst)
		up_read(local_req, `ADDR_SET_FWD) |=> !status_byte[`BIT_FWD_MODE])
		else $error("forwarding mode bit wrong");
	chk_fwd_level: assert property (@(posedge clock) disable iff (srst)
		fwd_q && !nmrq_in_n && !host_q && io_side_irq_in_n
		|=> irq_priority_lines == ~`LVL_HOST)
		else $error("forwarded request not at level 2");
	chk_slot_id: assert property (@(posedge clock) disable iff (srst)
		local_req.valid && !local_req.write && local_req.addr == `ADDR_STATUS
		|=> rdata[3:0] == $past(slot_id))
		else $error("slot id wrong");
endmodule

/* sim/bus_agent.sv */
// partner model: backplane host, local processor and I/O interface request lines
module bus_agent (
	input wire logic clock, // controller clock
	output irq_ctrl_pkg::bus_req_t host_req, // backplane host access
	output irq_ctrl_pkg::bus_req_t local_req, // local processor access
	output logic local_fetch, // one pulse per processor fetch
	output logic io_side_irq_in_n, // I/O interface request, active low
	output logic nmrq_in_n // sensed backplane request, active low
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		host_req = '0;
		local_req = '0;
		local_fetch = 1'b0;
		io_side_irq_in_n = 1'b1;
		nmrq_in_n = 1'b1;
	end

	// ----------------------------------------------------------------
	// one access: strobe for exactly one edge, then a scrambled idle bus
	// ----------------------------------------------------------------
	task automatic acc(input logic host, input logic wr, input logic up, input logic lo,
		input logic [23:0] a, input logic [7:0] d);
		irq_ctrl_pkg::bus_req_t r;
		irq_ctrl_pkg::bus_req_t idle;
		r = '{valid: 1'b1, write: wr, upper: up, lower: lo, addr: a, wdata: d};
		idle = '{valid: 1'b0, write: ~wr, upper: ~up, lower: ~lo, addr: ~a, wdata: ~d};
		@(posedge clock);
		if (host) begin
			host_req <= r;
		end else begin
			local_req <= r;
		end
		@(posedge clock);
		if (host) begin
			host_req <= idle;
		end else begin
			local_req <= idle;
		end
	endtask

	// the modelled boot image keeps its start vector inside the ROM window
	task automatic fetch();
		@(posedge clock);
		local_fetch <= 1'b1;
		@(posedge clock);
		local_fetch <= 1'b0;
	endtask

	// the I/O side holds its request until software clears it at the source
	task automatic lines(input logic io_n, input logic nm_n);
		@(posedge clock);
		io_side_irq_in_n <= io_n;
		nmrq_in_n <= nm_n;
	endtask
endmodule

/* sim/coproc_irq_soft_reset_ctrl_tb.sv */
// self-checking bench for the interrupt and soft-reset controller
`include "irq_ctrl_cfg.svh"
module coproc_irq_soft_reset_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [3:0] slot_id = 4'h6;
	logic bp_reset_n = 1'b1;
	irq_ctrl_pkg::bus_req_t host_req;
	irq_ctrl_pkg::bus_req_t local_req;
	logic local_fetch;
	logic io_n;
	logic nm_n;
	logic [7:0] rdata;
	logic [2:0] irq;
	logic nmrq_out_n;
	logic proc_reset_n;
	logic boot_from_ram;
	int n_fail = 0;
	int checks_done = 0;
	logic [7:0] st;

	initial begin
		forever #50 clock = ~clock;
	end

	bus_agent agent_u (.clock(clock), .host_req(host_req), .local_req(local_req),
		.local_fetch(local_fetch), .io_side_irq_in_n(io_n), .nmrq_in_n(nm_n));

	coproc_irq_soft_reset_ctrl #(.TICK_CYCLES(4), .VEC_FETCHES(4)) dut_u (.clock(clock),
		.srst(srst), .host_req(host_req), .local_req(local_req), .local_fetch(local_fetch),
		.slot_id(slot_id), .io_side_irq_in_n(io_n), .nmrq_in_n(nm_n), .bp_reset_n(bp_reset_n),
		.rdata(rdata), .irq_priority_lines(irq), .nmrq_out_n(nmrq_out_n),
		.proc_reset_n(proc_reset_n), .boot_from_ram(boot_from_ram));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// outputs settle two edges after an access is taken; four leaves margin
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// lower lane only, so reading status never releases soft reset
	task automatic status();
		agent_u.acc(1'b0, 1'b0, 1'b0, 1'b1, `ADDR_STATUS, 8'h00);
		settle(3);
		st = rdata;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check({5'h0, irq}, 8'h07, "idle lines");
		check({6'h0, nmrq_out_n, boot_from_ram}, 8'h02, "req boot");
		check({7'h0, proc_reset_n}, 8'h01, "run");
		status();
		check(st, 8'hf6, "status");
		repeat (4) agent_u.fetch();
		settle(2);
		check({7'h0, boot_from_ram}, 8'h00, "rom boot");
		$display("reset test done");
	endtask

	task automatic t_host_irq();
		agent_u.acc(1'b1, 1'b0, 1'b1, 1'b0, `ADDR_SET_PROC, 8'h00);
		settle(4);
		check({5'h0, irq}, {5'h0, ~`LVL_HOST}, "level 2");
		status();
		check(st, 8'hd6, "status set");
		agent_u.lines(1'b0, 1'b1);
		settle(4);
		check({5'h0, irq}, {5'h0, ~`LVL_IO}, "highest");
		agent_u.lines(1'b1, 1'b1);
		agent_u.acc(1'b0, 1'b0, 1'b1, 1'b0, `ADDR_CLR_PROC, 8'h00);
		settle(4);
		check({5'h0, irq}, 8'h07, "cleared");
		status();
		check(st, 8'hf6, "status clr");
		$display("host irq test done");
	endtask

	task automatic t_proc_to_host();
		agent_u.acc(1'b0, 1'b0, 1'b1, 1'b0, `ADDR_SET_HOST, 8'h00);
		settle(4);
		check({7'h0, nmrq_out_n}, 8'h00, "req on");
		status();
		check(st, 8'he6, "status req");
		agent_u.acc(1'b1, 1'b0, 1'b1, 1'b0, `ADDR_CLR_HOST, 8'h00);
		settle(4);
		check({7'h0, nmrq_out_n}, 8'h01, "req off");
		status();
		check(st, 8'hf6, "status noreq");
		$display("proc to host test done");
	endtask

	task automatic t_io_irq();
		agent_u.lines(1'b0, 1'b1);
		settle(4);
		check({5'h0, irq}, {5'h0, ~`LVL_IO}, "level 3");
		status();
		check(st, 8'hf6, "no io bit");
		agent_u.lines(1'b1, 1'b1);
		settle(4);
		check({5'h0, irq}, 8'h07, "io gone");
		$display("io irq test done");
	endtask

	task automatic t_forward();
		agent_u.acc(1'b0, 1'b0, 1'b1, 1'b0, `ADDR_SET_FWD, 8'h00);
		status();
		check(st, 8'h76, "mode on");
		agent_u.lines(1'b1, 1'b0);
		settle(4);
		check({5'h0, irq}, {5'h0, ~`LVL_HOST}, "fwd level");
		status();
		check(st, 8'h76, "fwd no bit");
		agent_u.lines(1'b0, 1'b1);
		agent_u.acc(1'b0, 1'b0, 1'b1, 1'b0, `ADDR_SET_HOST, 8'h00);
		status();
		check(st, 8'h46, "poll bit");
		agent_u.lines(1'b1, 1'b1);
		agent_u.acc(1'b1, 1'b0, 1'b1, 1'b0, `ADDR_CLR_HOST, 8'h00);
		agent_u.acc(1'b1, 1'b0, 1'b1, 1'b0, `ADDR_CLR_FWD, 8'h00);
		status();
		check(st, 8'hf6, "mode off");
		$display("forward test done");
	endtask

	task automatic t_soft_reset();
		agent_u.acc(1'b0, 1'b0, 1'b1, 1'b0, `ADDR_SET_FWD, 8'h00);
		agent_u.acc(1'b1, 1'b1, 1'b0, 1'b1, 24'hf00000, 8'h00);
		settle(4);
		check({7'h0, proc_reset_n}, 8'h00, "held");
		check({7'h0, boot_from_ram}, 8'h01, "ram boot");
		status();
		check(st, 8'h76, "kept");
		agent_u.acc(1'b1, 1'b0, 1'b1, 1'b0, `ADDR_STATUS, 8'h00);
		settle(4);
		check({7'h0, proc_reset_n}, 8'h01, "released");
		repeat (3) agent_u.fetch();
		settle(2);
		check({7'h0, boot_from_ram}, 8'h01, "3 fetches");
		agent_u.fetch();
		settle(2);
		check({7'h0, boot_from_ram}, 8'h00, "4 fetches");
		agent_u.acc(1'b1, 1'b1, 1'b0, 1'b1, 24'hf7a5c3, 8'h5a);
		settle(4);
		check({7'h0, proc_reset_n}, 8'h00, "held any");
		@(posedge clock);
		bp_reset_n <= 1'b0;
		settle(4);
		check({7'h0, proc_reset_n}, 8'h01, "bp release");
		@(posedge clock);
		bp_reset_n <= 1'b1;
		agent_u.acc(1'b0, 1'b0, 1'b1, 1'b0, `ADDR_CLR_FWD, 8'h00);
		$display("soft reset test done");
	endtask

	task automatic t_timer();
		int i;
		agent_u.acc(1'b0, 1'b1, 1'b0, 1'b1, `ADDR_TMR_HI, 8'h02);
		agent_u.acc(1'b0, 1'b1, 1'b0, 1'b1, `ADDR_TMR_LO, 8'h00);
		// reload 0200: the high count byte reads 01 for 256 ticks after the first decrement
		settle(20);
		agent_u.acc(1'b0, 1'b0, 1'b0, 1'b1, `ADDR_TMR_CNT_HI, 8'h00);
		settle(3);
		check(rdata, 8'h01, "count high");
		for (i = 0; i < 4000 && irq !== ~`LVL_TIMER; i++) begin
			settle(1);
		end
		check({5'h0, irq}, {5'h0, ~`LVL_TIMER}, "level 1");
		if (i == 4000) begin
			results();
		end
		status();
		check(st, 8'hb6, "timer bit");
		agent_u.acc(1'b0, 1'b0, 1'b0, 1'b1, `ADDR_CLR_TIMER, 8'h00);
		settle(4);
		check({5'h0, irq}, 8'h07, "timer clr");
		$display("timer test done");
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		n_fail++;
		results();
	end

	initial begin
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		settle(4);
		t_reset();
		t_host_irq();
		t_proc_to_host();
		t_io_irq();
		t_forward();
		t_soft_reset();
		t_timer();
		results();
	end
endmodule
